// *** src/optword_params.svh ***
// constants for the option word decoder: field positions, codes and wait counts
`ifndef OPTWORD_PARAMS_SVH
`define OPTWORD_PARAMS_SVH
// register byte offsets
`define OFS_WORD0 12'h000
`define OFS_WORD1 12'h004
`define OFS_STATUS 12'h008
`define OFS_WAIT 12'h00C
`define OFS_RTFREQ 12'h010
// word 0 fields
`define W0_WARMUP 13
`define W0_DEGL_HI 12
`define W0_DEGL_LO 11
`define W0_SLOWSTART 10
`define W0_LOWPWR 9
`define W0_BOR_HI 8
`define W0_BOR_LO 7
`define W0_RSTPIN 6
`define W0_WDOG 5
`define W0_NRWIDTH 4
`define W0_NRDIS_N 3
`define W0_GUARD_HI 2
`define W0_GUARD_LO 0
// word 1 fields
`define W1_SLOWRATE 13
`define W1_FREQ_HI 5
`define W1_FREQ_LO 4
`define W1_CLKPIN 1
`define W1_CLKDRV 0
// reset values of the words before a load
`define WORD0_RESET 16'h0000
`define WORD1_RESET 16'h0010
// codes
`define GUARD_OPEN 3'h5
`define FREQ_INVALID 2'h0
`define FREQ_8M 2'h1
`define DEGL_BYPASS 2'h3
// wait counts in clocks, power-on wait in ms
`define WARMUP_SHORT 8'h08
`define WARMUP_LONG 8'h20
`define SUB_WAIT 8'h08
`define POR_WAIT_MS 16
// timing
`define CLK_MHZ 250
`define NR_SHORT 6'h08
`define NR_LONG 6'h20
`endif

// *** src/optword_pkg.sv ***
// types shared by the option word decoder
package optword_pkg;
  typedef enum logic [2:0] {
    ST_LOAD0 = 3'b001,
    ST_LOAD1 = 3'b010,
    ST_DONE = 3'b100
  } load_state_t;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_GREEN = 2'h1,
    MODE_IDLE = 2'h2,
    MODE_SLEEP = 2'h3
  } cpu_mode_t;
endpackage

// *** src/optword_store.sv ***
// two-word nonvolatile option store model with registered read data
`timescale 1ns/100ps
module optword_store
  import optword_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // programming port
  input wire logic prog_we,
  input wire logic prog_addr,
  input wire logic [15:0] prog_data,
  // read port
  input wire logic rd_addr,
  output logic [15:0] rd_data
);
  `include "optword_params.svh"
  typedef struct packed {
    logic [1:0][15:0] mem;
    logic [15:0] rd;
  } store_t;
  store_t s_reg;
  store_t s_next;

  // programmer writes land in the array; read data always from a register
  always_comb begin
    s_next = s_reg;
    if (prog_we) begin
      s_next.mem[prog_addr] = prog_data;
    end
    s_next.rd = s_reg.mem[rd_addr];
  end

  // contents survive reset, as nonvolatile storage does
  always_ff @(posedge aclk) begin
    s_reg <= s_next;
    if (!aresetn) begin
      s_reg.rd <= 16'h0000;
    end
  end

  assign rd_data = s_reg.rd;
endmodule // optword_store

// *** src/option_word_decoder.sv ***
// option word decoder: loads two configuration words and drives static settings
//
// Overview of operation
// - warm-up bit 13 of word 0 picks 8 main clocks clear, 32 set
// - fast mode at 12/16 MHz waits 32 clocks, plus settle when the peripheral clock was stopped, plus 16 ms when power_on_reset_flag is set
// - at 8 MHz use warm-up count; slow mode waits settle plus 8 sub clocks
// - deglitch code 00/01/10 gives 50/100/150 ns; 11 bypasses filters
// - bit 10 set starts core in slow green mode after reset
// - brownout code: 00 power-on only, 01 2.5V, 10 3.6V, 11 4.2V
// - bit 6 set makes the dual-use pin an active-low external reset
// - width bit set accepts 8-period pulses, clear needs 32 periods
// - noise filter enable bit 3 is active low
// - noise filter forced off in green, idle and sleep modes
// - eeprom protection off only for guard code 101
// - word 1 bit 13 runs slow clock at 32 kHz set, 16 kHz clear
// - watchdog timebase always 16 kHz regardless of slow clock choice
// - frequency code 01 8 MHz, 10 12 MHz, 11 16 MHz, 00 invalid
// - configured frequency seeds the run-time frequency field software may change
// - clock pin mode bit clear keeps general I/O, set gives clock output
// - clock drive bit set makes the pin open-drain, clear drives cycle clock
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
module option_word_decoder
  import optword_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // programmer port into the option store
  input wire logic prog_we,
  input wire logic prog_addr,
  input wire logic [15:0] prog_data,
  // current cpu mode and settle time from the clock unit
  input wire logic [1:0] cpu_mode,
  input wire logic peripheral_clock_keep,
  input wire logic [7:0] stabilisation_time,
  input wire logic power_on_reset_flag,
  // axi4-lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // decoded settings
  output logic config_valid,
  output logic [7:0] osc_warmup_count,
  output logic [7:0] fast_entry_wait,
  output logic [7:0] slow_entry_wait,
  output logic fast_entry_add_por,
  output logic slow_entry_add_por,
  output logic [1:0] pin_deglitch_sel,
  output logic deglitch_bypass,
  output logic reset_start_slow_mode,
  output logic low_power_sel,
  output logic [1:0] brownout_level_sel,
  output logic ext_reset_pin_sel,
  output logic watchdog_on,
  output logic watchdog_clk_16k,
  output logic [5:0] noise_pulse_width,
  output logic noise_filter_on,
  output logic eeprom_protect,
  output logic slow_clock_rate_sel,
  output logic [1:0] main_clock_freq_sel,
  output logic freq_code_invalid,
  output logic clock_pin_mode_sel,
  output logic clock_output_drive_sel
);
  `include "optword_params.svh"

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    // loader and held words
    load_state_t st;
    logic [15:0] w0;
    logic [15:0] w1;
    logic valid;
    logic [1:0] rt_freq;
    // wait counts and filter state
    logic [7:0] fast_wait;
    logic [7:0] slow_wait;
    logic fast_por;
    logic slow_por;
    logic nr_on;
    // write channel
    logic aw_ok;
    logic w_ok;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    // read channel
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    // registered decodes, so every output leaves a flip-flop
    logic [7:0] warmup;
    logic degl_byp;
    logic [5:0] nr_width;
    logic protect;
    logic freq_bad;
    logic wd16k;
  } state_t;
  state_t s_reg;
  state_t s_next;

  logic [15:0] store_rd;
  logic store_addr;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // guard pattern decode, reused for status and output
  function automatic logic guard_on(input logic [15:0] w);
    guard_on = (w[`W0_GUARD_HI:`W0_GUARD_LO] != `GUARD_OPEN);
  endfunction

  // warm-up count picked by the warm-up bit
  function automatic logic [7:0] warmup_of(input logic [15:0] w);
    warmup_of = w[`W0_WARMUP] ? `WARMUP_LONG : `WARMUP_SHORT;
  endfunction

  // nonvolatile words; read port registered inside the store
  optword_store u_store (
    .aclk(aclk),
    .aresetn(aresetn),
    .prog_we(prog_we),
    .prog_addr(prog_addr),
    .prog_data(prog_data),
    .rd_addr(store_addr),
    .rd_data(store_rd)
  );

  // the store is read word 0 then word 1 as the loader walks
  // word 1 is requested while word 0 is taken in, so the load ends in three edges
  assign store_addr = (s_reg.st != ST_LOAD0);

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [15:0] w0;
    logic [15:0] w1;
    logic [31:0] rd;
    logic rd_hit;
    logic sleepy;
    w0 = s_reg.w0;
    w1 = s_reg.w1;
    rd = 32'h0000_0000;
    rd_hit = 1'b1;
    sleepy = 1'b0;
    s_next = s_reg;

    // loader: one store read per word, then frozen until reset
    unique case (s_reg.st)
      ST_LOAD0: begin
        s_next.st = ST_LOAD1;
      end
      ST_LOAD1: begin
        s_next.w0 = store_rd;
        s_next.st = ST_DONE;
      end
      ST_DONE: begin
        if (!s_reg.valid) begin
          s_next.w1 = store_rd;
          s_next.rt_freq = store_rd[`W1_FREQ_HI:`W1_FREQ_LO];
          s_next.valid = 1'b1;
        end
      end
    endcase

    // wait counts by frequency; 12/16 MHz use the fixed long warm-up
    if (w1[`W1_FREQ_HI:`W1_FREQ_LO] == `FREQ_8M) begin
      s_next.fast_wait = warmup_of(w0);
    end else begin
      s_next.fast_wait = `WARMUP_LONG;
    end
    // settle time added to the fast wait only when peripheral clock was stopped; the slow wait always adds it
    if (!peripheral_clock_keep) begin
      s_next.fast_wait = 8'(s_next.fast_wait + stabilisation_time);
    end
    s_next.slow_wait = 8'(`SUB_WAIT + stabilisation_time);
    // the 16 ms power-on wait is only flagged; the clock unit counts it
    s_next.fast_por = power_on_reset_flag;
    s_next.slow_por = power_on_reset_flag;

    // noise filter: off when disabled or outside normal mode
    // mode is registered here, so the filter drops one edge after the mode does
    sleepy = (cpu_mode != MODE_NORMAL);
    s_next.nr_on = s_reg.valid && !w0[`W0_NRDIS_N] && !sleepy;

    // write channel: capture address and data in either order
    // ready pulses one cycle; no new request is taken until the response ends
    s_next.awready = 1'b0;
    s_next.wready = 1'b0;
    if (s_axi_awvalid && !s_reg.aw_ok && !s_reg.awready && !s_reg.bvalid) begin
      s_next.awready = 1'b1;
      s_next.aw_ok = 1'b1;
      s_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_reg.w_ok && !s_reg.wready && !s_reg.bvalid) begin
      s_next.wready = 1'b1;
      s_next.w_ok = 1'b1;
      s_next.wdata = s_axi_wdata;
      s_next.wstrb = s_axi_wstrb;
    end
    // a write that lands before the load ends is overwritten by the word 1 code
    // read-only words answer okay so software may write them without harm
    // only the run-time frequency field is writable; words are read-only
    if (s_reg.aw_ok && s_reg.w_ok && !s_reg.bvalid) begin
      s_next.aw_ok = 1'b0;
      s_next.w_ok = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = 2'h0;
      if (s_reg.awaddr == `OFS_RTFREQ) begin
        if (s_reg.wstrb[0]) begin
          s_next.rt_freq = s_reg.wdata[1:0];
        end
      end else if (s_reg.awaddr != `OFS_WORD0 && s_reg.awaddr != `OFS_WORD1 &&
                   s_reg.awaddr != `OFS_STATUS && s_reg.awaddr != `OFS_WAIT) begin
        s_next.bresp = 2'h2;
      end
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end

    // read channel: one read at a time, answer valid in the same cycle as the handshake
    // unmapped reads answer with a slave error and zero data
    s_next.arready = 1'b0;
    if (s_axi_arvalid && !s_reg.arready && !s_reg.rvalid) begin
      s_next.arready = 1'b1;
      unique case (s_axi_araddr)
        `OFS_WORD0: rd = {16'h0000, w0};
        `OFS_WORD1: rd = {16'h0000, w1};
        `OFS_STATUS: rd = {28'h000_0000, guard_on(w0), s_reg.nr_on,
                           (w1[`W1_FREQ_HI:`W1_FREQ_LO] == `FREQ_INVALID), s_reg.valid};
        `OFS_WAIT: rd = {16'h0000, s_reg.slow_wait, s_reg.fast_wait};
        `OFS_RTFREQ: rd = {30'h0000_0000, s_reg.rt_freq};
        default: rd_hit = 1'b0;
      endcase
      s_next.rvalid = 1'b1;
      s_next.rdata = rd;
      s_next.rresp = rd_hit ? 2'h0 : 2'h2;
    end
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end

    // decode from the next words so each output lands with its word, no lag
    s_next.warmup = warmup_of(s_next.w0);
    s_next.degl_byp = (s_next.w0[`W0_DEGL_HI:`W0_DEGL_LO] == `DEGL_BYPASS);
    s_next.nr_width = s_next.w0[`W0_NRWIDTH] ? `NR_SHORT : `NR_LONG;
    s_next.protect = guard_on(s_next.w0);
    s_next.freq_bad = (s_next.rt_freq == `FREQ_INVALID);
    // the watchdog timebase ignores the slow clock choice
    s_next.wd16k = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers; reset restarts the load so the held words change only across reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.st <= ST_LOAD0;
      s_reg.w0 <= `WORD0_RESET;
      s_reg.w1 <= `WORD1_RESET;
      s_reg.rt_freq <= `FREQ_8M;
      // decoded fields match the reset words so no decoded output jumps at release
      s_reg.warmup <= `WARMUP_SHORT;
      s_reg.nr_width <= `NR_LONG;
      s_reg.protect <= 1'b1;
      s_reg.wd16k <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops
  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign config_valid = s_reg.valid;

  // decode of the held words, the run-time frequency and the clock unit inputs
  // wait settings
  assign osc_warmup_count = s_reg.warmup;
  assign fast_entry_wait = s_reg.fast_wait;
  assign slow_entry_wait = s_reg.slow_wait;
  assign fast_entry_add_por = s_reg.fast_por;
  assign slow_entry_add_por = s_reg.slow_por;

  // pin, reset and filter settings
  assign pin_deglitch_sel = s_reg.w0[`W0_DEGL_HI:`W0_DEGL_LO];
  assign deglitch_bypass = s_reg.degl_byp;
  assign reset_start_slow_mode = s_reg.w0[`W0_SLOWSTART];
  assign low_power_sel = s_reg.w0[`W0_LOWPWR];
  assign brownout_level_sel = s_reg.w0[`W0_BOR_HI:`W0_BOR_LO];
  // pin drives no output itself; software keeps it an input when reset
  assign ext_reset_pin_sel = s_reg.w0[`W0_RSTPIN];
  assign watchdog_on = s_reg.w0[`W0_WDOG];
  assign watchdog_clk_16k = s_reg.wd16k;
  assign noise_pulse_width = s_reg.nr_width;
  assign noise_filter_on = s_reg.nr_on;
  assign eeprom_protect = s_reg.protect;

  // clock settings
  assign slow_clock_rate_sel = s_reg.w1[`W1_SLOWRATE];
  assign main_clock_freq_sel = s_reg.rt_freq;
  assign freq_code_invalid = s_reg.freq_bad;
  assign clock_pin_mode_sel = s_reg.w1[`W1_CLKPIN];
  assign clock_output_drive_sel = s_reg.w1[`W1_CLKDRV];
  // unused word bits are ignored by the decode
endmodule // option_word_decoder

// *** verification/option_word_decoder_sva.sv ***
// assertion checker for the option word decoder, bound to its top module
`timescale 1ns/100ps
module option_word_decoder_sva
  import optword_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // watched inputs
  input wire logic [1:0] cpu_mode,
  input wire logic [7:0] stabilisation_time,
  input wire logic power_on_reset_flag,
  // watched outputs
  input wire logic config_valid,
  input wire logic [7:0] slow_entry_wait,
  input wire logic fast_entry_add_por,
  input wire logic slow_entry_add_por,
  input wire logic [1:0] pin_deglitch_sel,
  input wire logic deglitch_bypass,
  input wire logic [1:0] brownout_level_sel,
  input wire logic ext_reset_pin_sel,
  input wire logic watchdog_on,
  input wire logic watchdog_clk_16k,
  input wire logic noise_filter_on
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////
  // load finishes within a few edges and then stays put
  a_load_time: assert property ($rose(aresetn) |-> ##[1:4] config_valid)
    else $error("settings not loaded after reset");
  a_valid_sticky: assert property (config_valid |=> config_valid)
    else $error("valid flag dropped without reset");
  // settings must not drift while loaded
  a_settings_hold: assert property (config_valid && $past(config_valid) |->
    $stable(watchdog_on) && $stable(brownout_level_sel) && $stable(ext_reset_pin_sel)
    && $stable(pin_deglitch_sel))
    else $error("decoded setting changed while loaded");
  a_bypass_code: assert property (config_valid |->
    deglitch_bypass == (pin_deglitch_sel == 2'h3))
    else $error("deglitch bypass disagrees with code");
  // slow entry wait follows settle time one cycle later
  a_slow_wait: assert property (aresetn |=>
    slow_entry_wait == $past(stabilisation_time) + 8'h08)
    else $error("slow entry wait wrong");
  a_noise_forced_off: assert property (cpu_mode != MODE_NORMAL |=> !noise_filter_on)
    else $error("noise filter on outside normal mode");
  a_wdog_clock: assert property (config_valid |-> watchdog_clk_16k)
    else $error("watchdog timebase not fixed");
  a_por_add: assert property (aresetn |=>
    fast_entry_add_por == $past(power_on_reset_flag)
    && slow_entry_add_por == $past(power_on_reset_flag))
    else $error("power-on wait flag not copied");
  // main scenarios reached
  c_loaded: cover property ($rose(config_valid));
  c_noise_on: cover property (noise_filter_on);
  c_bypass: cover property (config_valid && deglitch_bypass);
endmodule // option_word_decoder_sva

bind option_word_decoder option_word_decoder_sva chk (.aclk, .aresetn, .cpu_mode,
  .stabilisation_time, .power_on_reset_flag, .config_valid, .slow_entry_wait,
  .fast_entry_add_por, .slow_entry_add_por, .pin_deglitch_sel, .deglitch_bypass,
  .brownout_level_sel, .ext_reset_pin_sel, .watchdog_on, .watchdog_clk_16k, .noise_filter_on);

// *** verification/option_programmer.sv ***
// programmer model: writes both option words into the store
`timescale 1ns/100ps
module option_programmer (
  // clock
  input wire logic aclk,
  // request from the bench
  input wire logic go,
  input wire logic [15:0] w0,
  input wire logic [15:0] w1,
  // store programming port
  output logic prog_we,
  output logic prog_addr,
  output logic [15:0] prog_data
);
  logic step_reg = 1'b0;
  initial {prog_we, prog_addr, prog_data} = '0;
  // word 0 then word 1; idle data toggles so nothing leans on stale bits
  always @(posedge aclk) begin
    step_reg <= go;
    prog_we <= go || step_reg;
    prog_addr <= step_reg;
    // word 0 bit 11 is kept: it carries the low deglitch bit
    prog_data <= go ? (w0 & 16'h3fff) : step_reg ? (w1 & 16'h2033) : ~prog_data;
  end
endmodule // option_programmer

// *** verification/tb_option_word_decoder.sv ***
// self-checking bench for the option word decoder
`timescale 1ns/100ps
module tb_option_word_decoder;
  import optword_pkg::*;
  logic aclk, aresetn, go, prog_we, prog_addr, peripheral_clock_keep, power_on_reset_flag;
  logic [15:0] prog_data, w0, w1, x0, x1;
  logic [1:0] cpu_mode, s_axi_bresp, s_axi_rresp, pin_deglitch_sel, brownout_level_sel;
  logic [1:0] main_clock_freq_sel;
  logic [7:0] stabilisation_time, osc_warmup_count, fast_entry_wait, slow_entry_wait, wu, fw, sw;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [5:0] noise_pulse_width;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, config_valid, cv_d;
  logic fast_entry_add_por, slow_entry_add_por, deglitch_bypass, reset_start_slow_mode;
  logic low_power_sel, ext_reset_pin_sel, watchdog_on, watchdog_clk_16k, noise_filter_on;
  logic eeprom_protect, slow_clock_rate_sel, freq_code_invalid;
  logic clock_pin_mode_sel, clock_output_drive_sel;
  logic [49:0] cfg_q[$];
  logic [33:0] ax_q[$];
  int checks = 0;
  int fail_count = 0;
  int seed = 32'h0000_ef0f;
  wire [49:0] cfg_seen = {osc_warmup_count, fast_entry_wait, slow_entry_wait, pin_deglitch_sel,
    deglitch_bypass, reset_start_slow_mode, low_power_sel, brownout_level_sel, ext_reset_pin_sel,
    watchdog_on, watchdog_clk_16k, noise_pulse_width, noise_filter_on, eeprom_protect,
    slow_clock_rate_sel, main_clock_freq_sel, freq_code_invalid, clock_pin_mode_sel,
    clock_output_drive_sel, fast_entry_add_por, slow_entry_add_por};

  option_word_decoder dut (.*);
  option_programmer prog (.*);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string n, input logic [49:0] e, input logic [49:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic close_out;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic stall;
    fail_count++;
    close_out();
  endtask
  // write: address and data offered together, bready held until the answer
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    @(posedge aclk);
    ax_q.push_back({r, 32'h0000_0000});
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    if (n == 50) stall();
  endtask
  task automatic axi_read(input logic [11:0] a, input logic [33:0] e);
    int n;
    @(posedge aclk);
    ax_q.push_back(e);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    if (n == 50) stall();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // watchers: oldest note against each result as it appears
  always @(posedge aclk) begin
    cv_d <= config_valid;
    if (config_valid === 1'b1 && cv_d === 1'b0) begin
      repeat (2) @(posedge aclk);
      check("settings", cfg_q.pop_front(), cfg_seen);
    end
  end
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      check("read", ax_q.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
      check("bresp", ax_q.pop_front() >> 32, s_axi_bresp);
  end
  ////////////////////////////////////////////////////////////////////////////
  // the loop sets every code of the coded fields: each guard code once, each 2-bit code twice
  initial begin
    int n;
    logic [15:0] a, b;
    {aresetn, go, cpu_mode, peripheral_clock_keep, power_on_reset_flag} = '0;
    {stabilisation_time, w0, w1, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    // reset stays asserted until the first words are in the store
    repeat (5) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      a = 16'($random(seed));
      b = 16'($random(seed));
      {a[12:11], a[8:7], a[2:0], b[5:4]} = {i[1:0], i[1:0], i[2:0], i[1:0]};
      x0 = a & 16'h3fff;
      x1 = b & 16'h2033;
      @(posedge aclk);
      {w0, w1, go} <= {a, b, 1'b1};
      {cpu_mode, peripheral_clock_keep} <= {i[2:1], i[2]};
      {stabilisation_time, power_on_reset_flag} <= 9'($random(seed));
      @(posedge aclk);
      go <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      wu = x0[13] ? 8'h20 : 8'h08;
      fw = (x1[5:4] == 2'h1 ? wu : 8'h20) + (peripheral_clock_keep ? 8'h00 : stabilisation_time);
      sw = stabilisation_time + 8'h08;
      cfg_q.push_back({wu, fw, sw, x0[12:11], x0[12:11] == 2'h3, x0[10:5], 1'b1,
        x0[4] ? 6'h08 : 6'h20, !x0[3] && cpu_mode == MODE_NORMAL, x0[2:0] != 3'h5,
        x1[13], x1[5:4], x1[5:4] == 2'h0, x1[1:0], {2{power_on_reset_flag}}});
      aresetn <= 1'b1;
      n = 0;
      while (config_valid !== 1'b1 && n < 20) begin
        @(posedge aclk);
        n++;
      end
      if (n == 20) stall();
      axi_read(12'h000, {18'h0_0000, x0});
      axi_read(12'h00C, {18'h0_0000, sw, fw});
      axi_read(12'h008, {30'h0000_0000, x0[2:0] != 3'h5,
        !x0[3] && cpu_mode == MODE_NORMAL, x1[5:4] == 2'h0, 1'b1});
      axi_write(12'h000, 32'h0000_ffff, 2'h0);
      axi_read(12'h004, {18'h0_0000, x1});
      axi_read(12'h000, {18'h0_0000, x0});
      axi_read(12'h010, {32'h0000_0000, x1[5:4]});
      axi_write(12'h010, {31'h0000_0001, i[0]}, 2'h0);
      axi_read(12'h010, {33'h0_0000_0001, i[0]});
      axi_write(12'h020, 32'h0000_0000, 2'h2);
    end
    repeat (5) @(posedge aclk);
    close_out();
  end
endmodule // tb_option_word_decoder
